// >>> logic/door_drv_pkg.sv
// constants shared by the serial control bank and its pin synchroniser
// assumes a single 125 MHz core clock; all timing counts derive from it
package door_drv_pkg;
    localparam int CLK_NS = 8;
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] FRAME_LEN = 5'h18;
    localparam logic [4:0] CNT_MAX = 5'h1f;

    // control word bit positions
    localparam int SEL_BIT = 0;
    localparam int ENABLE_BIT = 23;
    localparam int CLEAR_BIT = 22;
    localparam int DUTY_BIT = 21;
    localparam int RECOV_DIS_BIT = 20;
    localparam int MON_HI_BIT = 19;
    localparam int MON_LO_BIT = 18;

    // status word bit positions
    localparam int ST_ALWAYS_BIT = 23;
    localparam int ST_OV_BIT = 22;
    localparam int ST_UV_BIT = 21;
    localparam int ST_SHUT_BIT = 20;
    localparam int ST_WARN_BIT = 19;
    localparam int ST_NRDY_BIT = 18;
    localparam int ST_NOERR_BIT = 0;

    // driver index -> control/status position:
    // 0/1 bridge a lower/upper, 2/3 bridge b, 4/5 bridge c, 6 high side a, 7 high side b, 8 high side power
    localparam int NUM_DRV = 9;
    localparam int NUM_BRIDGE = 3;
    localparam int DRV_POS [NUM_DRV] = '{1, 2, 3, 4, 5, 6, 14, 15, 17};
    // recovery enable positions in control word 1, only the high-side drivers have one
    localparam logic [8:0] REC_AVAIL = 9'h1c0;
    localparam int REC_POS [NUM_DRV] = '{0, 0, 0, 0, 0, 0, 19, 20, 22};

    // overcurrent retry pulsing
    localparam int RETRY_PERIOD_NS = 8000;
    localparam int DUTY_LOW_PCT = 12;
    localparam int DUTY_HIGH_PCT = 25;
    localparam int RETRY_CYCLES = RETRY_PERIOD_NS / CLK_NS;
    localparam logic [15:0] RETRY_LAST = 16'(RETRY_CYCLES - 1);
    localparam logic [15:0] ON_LOW = 16'(RETRY_CYCLES * DUTY_LOW_PCT / 100);
    localparam logic [15:0] ON_HIGH = 16'(RETRY_CYCLES * DUTY_HIGH_PCT / 100);

    // charge-pump settling after leaving standby
    localparam int SETTLE_TIME_NS = 50000;
    localparam int SETTLE_CYCLES_DEF = (SETTLE_TIME_NS + CLK_NS - 1) / CLK_NS;

    // synchroniser lane layout
    localparam int SYNC_W = 18;
    localparam int L_SCLK = 0;
    localparam int L_CSN = 1;
    localparam int L_DI = 2;
    localparam int L_PA = 3;
    localparam int L_PB = 4;
    localparam int L_OC = 5;
    localparam int L_OV = 14;
    localparam int L_UV = 15;
    localparam int L_SHUT = 16;
    localparam int L_WARN = 17;
    localparam logic [SYNC_W-1:0] SYNC_INIT = 18'h00002;
endpackage

// >>> logic/pin_sync.sv
// three-stage synchroniser for a bundle of asynchronous pins
// assumes pins are static for several core clocks between changes
`timescale 1ns/1ps
module pin_sync
    import door_drv_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] pins_i,
    output logic [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_t;

    sync_t s;
    sync_t next_s;

    // a change is taken only once the second and third stage agree
    always_comb begin
        next_s.s1 = pins_i;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.lvl = (~(s.s2 ^ s.s3) & s.s2) | ((s.s2 ^ s.s3) & s.lvl);
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s <= {INIT, INIT, INIT, INIT};
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.lvl;
endmodule

// >>> logic/door_drv_bank.sv
// serial control word / status word bank of a load driver, core clock domain
// assumes serial pins and fault comparators are asynchronous and slow vs clk_i
`timescale 1ns/1ps
module door_drv_bank
    import door_drv_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sclk_i,
    input wire logic chip_select_n_i,
    input wire logic serial_in_i,
    input wire logic pulse_input_a_i,
    input wire logic pulse_input_b_i,
    input wire logic [8:0] gate_enable_i,
    input wire logic [8:0] gate_source_b_i,
    input wire logic [8:0] overcurrent_i,
    input wire logic overvoltage_i,
    input wire logic undervoltage_i,
    input wire logic thermal_shutdown_i,
    input wire logic thermal_warning_i,
    output logic serial_out_o,
    output logic serial_out_oe_n_o,
    output logic [8:0] drive_o,
    output logic [1:0] monitor_sel_o
);
    typedef struct packed {
        logic sclk_q;
        logic csn_q;
        logic [23:0] rx;
        logic [4:0] cnt;
        logic loaded;
        logic [23:0] tx;
        logic [23:0] ctrl0;
        logic [23:0] ctrl1;
        logic active;
        logic nrdy;
        logic [15:0] settle;
        logic [15:0] retry;
        logic ov;
        logic uv;
        logic shut;
        logic warn;
        logic [8:0] oc;
        logic [8:0] drive;
        logic [1:0] mon;
        logic do_bit;
        logic do_oe_n;
    } state_t;

    state_t s;
    state_t next_s;
    logic [SYNC_W-1:0] lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic csn_fall;
    logic csn_rise;
    logic commit;
    logic clear_st;
    logic no_error;
    logic on_window;
    logic supply_block;
    logic [8:0] oc_in;
    logic [23:0] st0;
    logic [23:0] st1;

    pin_sync #(
        .W(SYNC_W),
        .INIT(SYNC_INIT)
    ) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pins_i({thermal_warning_i, thermal_shutdown_i, undervoltage_i, overvoltage_i, overcurrent_i,
                 pulse_input_b_i, pulse_input_a_i, serial_in_i, chip_select_n_i, sclk_i}),
        .level_o(lvl)
    );

    assign oc_in = lvl[L_OC +: NUM_DRV];
    assign sclk_rise = lvl[L_SCLK] & ~s.sclk_q;
    assign sclk_fall = ~lvl[L_SCLK] & s.sclk_q;
    assign csn_fall = ~lvl[L_CSN] & s.csn_q;
    assign csn_rise = lvl[L_CSN] & ~s.csn_q;
    assign commit = csn_rise && (s.cnt == FRAME_LEN);
    // clear bit only has that meaning in control word 0
    assign clear_st = commit && !s.rx[SEL_BIT] && s.rx[CLEAR_BIT];
    assign no_error = ~|{s.ov, s.uv, s.shut, s.warn, s.nrdy, s.oc};
    assign on_window = s.retry < (s.ctrl0[DUTY_BIT] ? ON_HIGH : ON_LOW);
    // live supply fault always blocks; latched one blocks only with recovery disabled
    assign supply_block = lvl[L_OV] | lvl[L_UV] | (s.ctrl0[RECOV_DIS_BIT] & (s.ov | s.uv));

    // status words; unused positions stay zero
    always_comb begin
        st0 = '0;
        st0[ST_ALWAYS_BIT] = 1'b1;
        st0[ST_OV_BIT] = s.ov;
        st0[ST_UV_BIT] = s.uv;
        st0[ST_SHUT_BIT] = s.shut;
        st0[ST_WARN_BIT] = s.warn;
        st0[ST_NRDY_BIT] = s.nrdy;
        st0[ST_NOERR_BIT] = no_error;
        for (int i = 0; i < NUM_DRV; i++) begin
            st0[DRV_POS[i]] = s.oc[i];
        end
        // open-load diagnostics are not modelled, their positions read zero
        st1 = '0;
        st1[23:18] = st0[23:18];
        st1[ST_NOERR_BIT] = no_error;
    end

    always_comb begin
        logic [8:0] want;
        logic pulse;
        logic rec;
        want = '0;
        pulse = 1'b0;
        rec = 1'b0;
        next_s = s;
        next_s.sclk_q = lvl[L_SCLK];
        next_s.csn_q = lvl[L_CSN];

        // serial shifting, lsb first
        if (csn_fall) begin
            next_s.cnt = '0;
            next_s.loaded = 1'b0;
            next_s.tx = st0;
        end
        if (sclk_rise && !s.csn_q) begin
            next_s.rx = {lvl[L_DI], s.rx[FRAME_BITS-1:1]};
            next_s.cnt = (s.cnt == CNT_MAX) ? s.cnt : s.cnt + 5'h01;
            if (!s.loaded) begin
                next_s.tx = lvl[L_DI] ? st1 : st0;
                next_s.loaded = 1'b1;
            end
        end
        if (sclk_fall && !s.csn_q && s.loaded) begin
            next_s.tx = {1'b0, s.tx[FRAME_BITS-1:1]};
        end
        next_s.do_bit = next_s.tx[0];
        next_s.do_oe_n = lvl[L_CSN];

        // sticky faults, a new event beats a clear in the same cycle
        next_s.ov = (s.ov & ~clear_st) | lvl[L_OV];
        next_s.uv = (s.uv & ~clear_st) | lvl[L_UV];
        next_s.shut = (s.shut & ~clear_st) | lvl[L_SHUT];
        next_s.warn = (s.warn & ~clear_st) | lvl[L_WARN];
        next_s.oc = (s.oc & ~{NUM_DRV{clear_st}}) | (oc_in & s.drive);

        // settling timer
        if (s.nrdy) begin
            if (s.settle == '0) begin
                next_s.nrdy = 1'b0;
            end else begin
                next_s.settle = s.settle - 16'h0001;
            end
        end

        // committed frame
        if (commit) begin
            if (!s.rx[ENABLE_BIT]) begin
                // standby wipes both words and the status bits; ov, uv, shut and warn reload from their live pins
                next_s.active = 1'b0;
                next_s.nrdy = 1'b0;
                next_s.ctrl0 = '0;
                next_s.ctrl1 = '0;
                next_s.ov = lvl[L_OV];
                next_s.uv = lvl[L_UV];
                next_s.shut = lvl[L_SHUT];
                next_s.warn = lvl[L_WARN];
                next_s.oc = '0;
            end else begin
                if (s.rx[SEL_BIT]) begin
                    next_s.ctrl1 = s.rx;
                end else begin
                    next_s.ctrl0 = s.rx;
                end
                next_s.active = 1'b1;
                if (!s.active) begin
                    next_s.nrdy = 1'b1;
                    next_s.settle = 16'(SETTLE_CYCLES - 1);
                end
            end
        end

        // retry period runs freely, one phase shared by all drivers
        next_s.retry = (s.retry == RETRY_LAST) ? '0 : s.retry + 16'h0001;

        // output enables
        for (int i = 0; i < NUM_DRV; i++) begin
            pulse = gate_source_b_i[i] ? lvl[L_PB] : lvl[L_PA];
            rec = REC_AVAIL[i] & s.ctrl1[REC_POS[i]];
            want[i] = s.ctrl0[DRV_POS[i]]
                & (~gate_enable_i[i] | pulse)
                & ~(s.oc[i] & ~(rec & on_window))
                & ~oc_in[i];
        end
        for (int b = 0; b < NUM_BRIDGE; b++) begin
            if (want[2*b] && want[2*b+1]) begin
                want[2*b +: 2] = 2'b00;
            end
        end
        if (!s.active || s.nrdy || s.shut || lvl[L_SHUT] || supply_block) begin
            want = '0;
        end
        next_s.drive = want;
        next_s.mon = s.ctrl0[MON_HI_BIT:MON_LO_BIT];
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s <= '0;
            s.sclk_q <= 1'b0;
            s.csn_q <= 1'b1;
            s.do_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign serial_out_o = s.do_bit;
    assign serial_out_oe_n_o = s.do_oe_n;
    assign drive_o = s.drive;
    assign monitor_sel_o = s.mon;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence frame_bad_end;
        csn_rise && (s.cnt != FRAME_LEN);
    endsequence

    sequence frame_word0_end;
        commit && !s.rx[SEL_BIT] && s.rx[ENABLE_BIT];
    endsequence

    a_short_frame: assert property (frame_bad_end |=> $stable(s.ctrl0) && $stable(s.ctrl1)
        && (s.active == $past(s.active)))
        else $error("frame of wrong length changed a control word");
    a_word_select: assert property (frame_word0_end |=> s.ctrl0 == $past(s.rx) && $stable(s.ctrl1))
        else $error("word 0 frame not stored in control word 0");
    a_clear_all: assert property (clear_st && !lvl[L_WARN] && !lvl[L_SHUT] && (oc_in == '0) |=>
        !s.warn && !s.shut && (s.oc == '0))
        else $error("status not cleared at frame end");
    a_monitor_sel: assert property (frame_word0_end ##2 1'b1 |->
        monitor_sel_o == $past(s.rx[MON_HI_BIT:MON_LO_BIT], 2))
        else $error("monitor select does not follow control bits");
    a_supply_hold: assert property (s.uv && s.ctrl0[RECOV_DIS_BIT] |=> drive_o == '0)
        else $error("output on after undervoltage with recovery disabled");
    a_shutdown_off: assert property ($rose(s.shut) |=> (drive_o == '0) [*3])
        else $error("output on during thermal shutdown");
    a_warn_hold: assert property (s.warn && !clear_st && !commit |=> s.warn)
        else $error("thermal warning dropped without clear");
    a_ready_wait: assert property (s.nrdy |=> drive_o == '0)
        else $error("output on before settling finished");
    a_bridge_excl: assert property ((drive_o[1:0] != 2'b11) && (drive_o[3:2] != 2'b11)
        && (drive_o[5:4] != 2'b11))
        else $error("half bridge shoot-through");
    a_oc_latch: assert property ((oc_in & s.drive) != '0 |=>
        ((s.oc & $past(oc_in & s.drive)) == $past(oc_in & s.drive)) && ((drive_o & $past(oc_in)) == '0))
        else $error("overcurrent not latched or driver not disabled");
    a_noerr_out: assert property (csn_fall |=> s.do_bit == $past(no_error) && !s.do_oe_n)
        else $error("serial out does not show no-error at frame start");
endmodule

// >>> verif/spi_master.sv
// serial master model for the bank's link pins, mode 0, lsb first
// assumes clk_i is the core clock; a link half period is ten core clocks
`timescale 1ns/1ps
module spi_master (
    input wire logic clk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic csn_o,
    output logic mosi_o
);
    // link clock stands low outside frames
    initial begin
        sclk_o = 1'b0;
        csn_o = 1'b1;
        mosi_o = 1'b0;
    end

    task automatic half();
        repeat (10) @(posedge clk_i);
    endtask

    // n other than 24 gives a frame the device must drop
    task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx = '0;
        csn_o <= 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            mosi_o <= tx[i % 24];
            half();
            rx[i % 24] = miso_i;
            sclk_o <= 1'b1;
            half();
            sclk_o <= 1'b0;
        end
        half();
        csn_o <= 1'b1;
        // released data line must not keep its last level
        mosi_o <= ~mosi_o;
        repeat (30) @(posedge clk_i);
    endtask
endmodule

// >>> verif/tb.sv
// self-checking bench for the serial control and status bank
// assumes the master model in spi_master.sv; settle count shortened
`timescale 1ns/1ps
module tb;
    import door_drv_pkg::*;
    localparam int SETTLE = 400;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sclk, csn, mosi, so, oe_n;
    logic pa = 1'b0, pb = 1'b0, ov = 1'b0, uv = 1'b0, shut = 1'b0, warn = 1'b0;
    logic [8:0] gen = '0, gsrc = '0, oc = '0, drive;
    logic [1:0] mon;
    logic [23:0] rx;
    int mismatches = 0;
    int cmp_count = 0;

    always #4 clk = ~clk;

    spi_master spi_master_i (.clk_i(clk), .miso_i(so), .sclk_o(sclk), .csn_o(csn), .mosi_o(mosi));

    door_drv_bank #(.SETTLE_CYCLES(SETTLE)) door_drv_bank_i (
        .clk_i(clk), .rstn_i(rstn), .sclk_i(sclk), .chip_select_n_i(csn),
        .serial_in_i(mosi), .pulse_input_a_i(pa), .pulse_input_b_i(pb),
        .gate_enable_i(gen), .gate_source_b_i(gsrc), .overcurrent_i(oc),
        .overvoltage_i(ov), .undervoltage_i(uv), .thermal_shutdown_i(shut),
        .thermal_warning_i(warn), .serial_out_o(so), .serial_out_oe_n_o(oe_n),
        .drive_o(drive), .monitor_sel_o(mon));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [23:0] tx);
        spi_master_i.xfer(tx, 24, rx);
    endtask

    // async fault pins pass three sync flops, so allow ten clocks
    task automatic settle();
        repeat (10) @(posedge clk);
    endtask

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic t_startup();
        chk(drive, 0);
        chk(oe_n, 1);
        wr(24'h800002);
        chk(drive, 0);
        wr(24'h800002);
        chk(rx, 24'h840000);
        chk(drive, 9'h001);
    endtask

    task automatic t_outputs();
        for (int m = 0; m < 4; m++) begin
            wr(24'h83ffd2 | (24'(m) << 18));
            chk(rx, 24'h800001);
            chk(drive, 9'h1e9);
            chk(mon, m);
        end
        wr(24'h800006);
        chk(drive, 0);
    endtask

    task automatic t_drop();
        wr(24'h804000);
        spi_master_i.xfer(24'h800002, 23, rx);
        chk(drive, 9'h040);
        spi_master_i.xfer(24'h800002, 25, rx);
        chk(drive, 9'h040);
        wr(24'h800001);
        chk(drive, 9'h040);
    endtask

    task automatic t_overcurrent();
        oc <= 9'h040;
        settle();
        chk(drive, 0);
        oc <= 9'h000;
        settle();
        chk(drive, 0);
        wr(24'hc04000);
        chk(rx, 24'h804000);
        chk(drive, 9'h040);
        wr(24'h804000);
        chk(rx, 24'h800001);
    endtask

    task automatic t_thermal();
        warn <= 1'b1;
        settle();
        chk(drive, 9'h040);
        warn <= 1'b0;
        shut <= 1'b1;
        settle();
        chk(drive, 0);
        shut <= 1'b0;
        settle();
        chk(drive, 0);
        wr(24'hc04000);
        chk(rx, 24'h980000);
        chk(drive, 9'h040);
    endtask

    task automatic t_undervoltage();
        wr(24'h904000);
        uv <= 1'b1;
        settle();
        chk(drive, 0);
        uv <= 1'b0;
        settle();
        chk(drive, 0);
        wr(24'hd04000);
        chk(rx, 24'ha00000);
        chk(drive, 9'h040);
        // recovery disable off: outputs come back by themselves
        wr(24'h804000);
        uv <= 1'b1;
        settle();
        chk(drive, 0);
        uv <= 1'b0;
        settle();
        chk(drive, 9'h040);
    endtask

    // count drive-on cycles of high side a over one whole retry period
    task automatic count_on(output int n);
        n = 0;
        repeat (RETRY_CYCLES) begin
            @(negedge clk);
            if (drive[6] === 1'b1)
                n++;
        end
        @(posedge clk);
    endtask

    task automatic t_retry();
        int n;
        n = 0;
        wr(24'h880001);
        wr(24'h804000);
        chk(drive, 9'h040);
        oc <= 9'h040;
        settle();
        oc <= 9'h000;
        settle();
        count_on(n);
        chk(n, RETRY_CYCLES * DUTY_LOW_PCT / 100);
        wr(24'ha04000);
        count_on(n);
        chk(n, RETRY_CYCLES * DUTY_HIGH_PCT / 100);
        wr(24'hc04000);
        settle();
        chk(drive, 9'h040);
    endtask

    task automatic t_gate();
        gen <= 9'h100;
        wr(24'h820000);
        chk(drive, 0);
        pa <= 1'b1;
        settle();
        chk(drive, 9'h100);
        gsrc <= 9'h100;
        settle();
        chk(drive, 0);
        pb <= 1'b1;
        settle();
        chk(drive, 9'h100);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_startup();
        t_outputs();
        t_drop();
        t_overcurrent();
        t_thermal();
        t_undervoltage();
        t_gate();
        t_retry();
        end_of_test();
    end
endmodule
